// >>> hdl/acd_clock_divider_config.v
// Register file and ratio decode for the audio clock-tree dividers.
// Assumes a plain synchronous register port; read data one cycle later.
`include "acd_consts.vh"

// What this block does
// R1: The PLL multiplier is a 9-bit value of high bit and low byte, code 0 reserved.
// R2: The multiplier high bit sits in bit 7 of its own register.
// R3: The N divider code 0 divides by 8, other codes by their value.
// R4: The PDM divider codes 0 to 4 divide by 1, 2, 4, 8, 16; 5 to 7 reserved.
// R5: The M divider in bits 7 to 2 divides by 64 at 0, else by the code.
// R6: The modulator divider in bits 1 to 0 divides by 1, 2, 4; 3 reserved.
// R7: Bit 2 of the high-bits register tops the primary bit-clock divider.
// R8: Bit 1 of that register tops the secondary bit-clock divider.
// R9: The primary bit-clock code 0 divides by 512, else by the code.
// R10: The secondary bit-clock divider uses the same encoding.
// R11: The analog N-M divider in bits 5 to 0 divides by 64 at 0, else by code.
// R12: Enable bits 2, 1, 0 turn on the N, M and PDM dividers.
// R13: With automatic clock detection on, programmed values are ignored.
// R14: Reserved bits read zero and cannot be written.
// R15: A disabled divider holds still and restarts cleanly when enabled.
module acd_clock_divider_config #(
	parameter AUTO_MUL = 9'd8,
	parameter AUTO_N = 10'd1,
	parameter AUTO_M = 10'd1,
	parameter AUTO_PDM = 10'd1,
	parameter AUTO_MOD = 10'd1,
	parameter AUTO_BCLK = 10'd1,
	parameter AUTO_NM = 10'd1
) (
	input wire clk,
	input wire rst,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output wire [7:0] regRdData,
	input wire autoDetectEn,
	output wire [8:0] pllMultiplier,
	output wire multiplierReserved,
	output wire [9:0] nStageRatio,
	output wire [9:0] mStageRatio,
	output wire [9:0] pdmRatio,
	output wire pdmReserved,
	output wire [9:0] modulatorRatio,
	output wire modulatorReserved,
	output wire [9:0] primaryBclkRatio,
	output wire [9:0] secondaryBclkRatio,
	output wire [9:0] analogNmRatio,
	output wire nStageTick,
	output wire mStageTick,
	output wire pdmTick
);
	reg [7:0] mulHi_r;
	reg [7:0] mulLo_r;
	reg [7:0] nPdm_r;
	reg [7:0] mMod_r;
	reg [7:0] bclkHi_r;
	reg [7:0] priLo_r;
	reg [7:0] secLo_r;
	reg [7:0] anaNm_r;
	reg [7:0] divEn_r;
	reg [7:0] rdData_nxt;
	reg [7:0] rdData_r;
	reg [8:0] mul_r;
	reg [8:0] mul_nxt;
	reg mulRsv_r;
	reg mulRsv_nxt;
	reg [9:0] nRatio_r;
	reg [9:0] nRatio_nxt;
	reg [9:0] mRatio_r;
	reg [9:0] mRatio_nxt;
	reg [9:0] pdmRatio_r;
	reg [9:0] pdmRatio_nxt;
	reg pdmRsv_r;
	reg pdmRsv_nxt;
	reg [9:0] modRatio_r;
	reg [9:0] modRatio_nxt;
	reg modRsv_r;
	reg modRsv_nxt;
	reg [9:0] priRatio_r;
	reg [9:0] priRatio_nxt;
	reg [9:0] secRatio_r;
	reg [9:0] secRatio_nxt;
	reg [9:0] nmRatio_r;
	reg [9:0] nmRatio_nxt;
	wire [8:0] mulCode;
	wire [8:0] priCode;
	wire [8:0] secCode;
	wire [2:0] nCode;
	wire [2:0] pdmCode;
	wire [5:0] mCode;
	wire [1:0] modCode;
	wire [5:0] nmCode;

	// Zero code means the full power of two of the field width
	function [9:0] zeroIsMax;
		input [8:0] code;
		input [9:0] maxVal;
		begin
			if (code == 9'h000)
				zeroIsMax = maxVal;
			else
				zeroIsMax = {1'b0, code};
		end
	endfunction

	// Power-of-two decode; reserved codes fall back to divide by one
	function [9:0] powTwo;
		input [2:0] code;
		input [2:0] maxCode;
		begin
			if (code > maxCode)
				powTwo = 10'h001;
			else
				powTwo = 10'h001 << code;
		end
	endfunction

	always @(posedge clk)
	begin
		if (rst)
			mulHi_r <= `ACD_RST_PLL_MUL_HI;
		else if (regWrite && regAddr == `ACD_OFF_PLL_MUL_HI)
			mulHi_r <= regWrData & `ACD_MASK_PLL_MUL_HI; // R2
	end

	always @(posedge clk)
	begin
		if (rst)
			mulLo_r <= `ACD_RST_PLL_MUL_LO;
		else if (regWrite && regAddr == `ACD_OFF_PLL_MUL_LO)
			mulLo_r <= regWrData;
	end

	always @(posedge clk)
	begin
		if (rst)
			nPdm_r <= `ACD_RST_N_PDM_SEL;
		else if (regWrite && regAddr == `ACD_OFF_N_PDM_SEL)
			nPdm_r <= regWrData & `ACD_MASK_N_PDM_SEL; // R14
	end

	always @(posedge clk)
	begin
		if (rst)
			mMod_r <= `ACD_RST_M_MOD_SEL;
		else if (regWrite && regAddr == `ACD_OFF_M_MOD_SEL)
			mMod_r <= regWrData;
	end

	always @(posedge clk)
	begin
		if (rst)
			bclkHi_r <= `ACD_RST_BCLK_HI;
		else if (regWrite && regAddr == `ACD_OFF_BCLK_HI)
			bclkHi_r <= regWrData & `ACD_MASK_BCLK_HI; // R14
	end

	always @(posedge clk)
	begin
		if (rst)
			priLo_r <= `ACD_RST_PRI_BCLK_LO;
		else if (regWrite && regAddr == `ACD_OFF_PRI_BCLK_LO)
			priLo_r <= regWrData;
	end

	always @(posedge clk)
	begin
		if (rst)
			secLo_r <= `ACD_RST_SEC_BCLK_LO;
		else if (regWrite && regAddr == `ACD_OFF_SEC_BCLK_LO)
			secLo_r <= regWrData;
	end

	always @(posedge clk)
	begin
		if (rst)
			anaNm_r <= `ACD_RST_ANA_NM_SEL;
		else if (regWrite && regAddr == `ACD_OFF_ANA_NM_SEL)
			anaNm_r <= regWrData & `ACD_MASK_ANA_NM_SEL; // R14
	end

	always @(posedge clk)
	begin
		if (rst)
			divEn_r <= `ACD_RST_DIV_EN;
		else if (regWrite && regAddr == `ACD_OFF_DIV_EN)
			divEn_r <= regWrData & `ACD_MASK_DIV_EN; // R14
	end

	// Unmapped addresses read zero
	always @*
	begin
		case (regAddr)
		`ACD_OFF_PLL_MUL_HI: rdData_nxt = mulHi_r;
		`ACD_OFF_PLL_MUL_LO: rdData_nxt = mulLo_r;
		`ACD_OFF_N_PDM_SEL: rdData_nxt = nPdm_r;
		`ACD_OFF_M_MOD_SEL: rdData_nxt = mMod_r;
		`ACD_OFF_BCLK_HI: rdData_nxt = bclkHi_r;
		`ACD_OFF_PRI_BCLK_LO: rdData_nxt = priLo_r;
		`ACD_OFF_SEC_BCLK_LO: rdData_nxt = secLo_r;
		`ACD_OFF_ANA_NM_SEL: rdData_nxt = anaNm_r;
		`ACD_OFF_DIV_EN: rdData_nxt = divEn_r;
		default: rdData_nxt = 8'h00;
		endcase
	end

	always @(posedge clk)
	begin
		if (rst)
			rdData_r <= 8'h00;
		else if (regRead)
			rdData_r <= rdData_nxt;
		else
			rdData_r <= 8'h00;
	end

	assign mulCode = {mulHi_r[`ACD_BIT_PLL_MUL_HI], mulLo_r}; // R1 R2
	assign priCode = {bclkHi_r[`ACD_BIT_PRI_BCLK_HI], priLo_r}; // R7
	assign secCode = {bclkHi_r[`ACD_BIT_SEC_BCLK_HI], secLo_r}; // R8
	assign nCode = nPdm_r[`ACD_N_HI:`ACD_N_LO];
	assign pdmCode = nPdm_r[`ACD_PDM_HI:`ACD_PDM_LO];
	assign mCode = mMod_r[`ACD_M_HI:`ACD_M_LO];
	assign modCode = mMod_r[`ACD_MOD_HI:`ACD_MOD_LO];
	assign nmCode = anaNm_r[`ACD_NM_HI:`ACD_NM_LO];

	// Auto detection overrides every programmed field
	always @*
	begin
		if (autoDetectEn)
		begin
			mul_nxt = AUTO_MUL; // R13
			mulRsv_nxt = 1'b0;
			nRatio_nxt = AUTO_N;
			mRatio_nxt = AUTO_M;
			pdmRatio_nxt = AUTO_PDM;
			pdmRsv_nxt = 1'b0;
			modRatio_nxt = AUTO_MOD;
			modRsv_nxt = 1'b0;
			priRatio_nxt = AUTO_BCLK;
			secRatio_nxt = AUTO_BCLK;
			nmRatio_nxt = AUTO_NM;
		end
		else
		begin
			mul_nxt = mulCode; // R1
			mulRsv_nxt = (mulCode == 9'h000); // R1
			nRatio_nxt = zeroIsMax({6'h00, nCode}, 10'd8); // R3
			mRatio_nxt = zeroIsMax({3'h0, mCode}, 10'd64); // R5
			pdmRatio_nxt = powTwo(pdmCode, 3'd4); // R4
			pdmRsv_nxt = (pdmCode > 3'd4); // R4
			modRatio_nxt = powTwo({1'b0, modCode}, 3'd2); // R6
			modRsv_nxt = (modCode == 2'd3); // R6
			priRatio_nxt = zeroIsMax(priCode, 10'd512); // R9
			secRatio_nxt = zeroIsMax(secCode, 10'd512); // R10
			nmRatio_nxt = zeroIsMax({3'h0, nmCode}, 10'd64); // R11
		end
	end

	// Ratios registered so divider inputs never glitch on a write
	always @(posedge clk)
	begin
		if (rst)
		begin
			mul_r <= 9'h008;
			mulRsv_r <= 1'b0;
			nRatio_r <= 10'h001;
			mRatio_r <= 10'h001;
			pdmRatio_r <= 10'h001;
			pdmRsv_r <= 1'b0;
			modRatio_r <= 10'h001;
			modRsv_r <= 1'b0;
			priRatio_r <= 10'h001;
			secRatio_r <= 10'h001;
			nmRatio_r <= 10'h001;
		end
		else
		begin
			mul_r <= mul_nxt;
			mulRsv_r <= mulRsv_nxt;
			nRatio_r <= nRatio_nxt;
			mRatio_r <= mRatio_nxt;
			pdmRatio_r <= pdmRatio_nxt;
			pdmRsv_r <= pdmRsv_nxt;
			modRatio_r <= modRatio_nxt;
			modRsv_r <= modRsv_nxt;
			priRatio_r <= priRatio_nxt;
			secRatio_r <= secRatio_nxt;
			nmRatio_r <= nmRatio_nxt;
		end
	end

	// Ports come straight from flip-flops
	assign regRdData = rdData_r;
	assign pllMultiplier = mul_r;
	assign multiplierReserved = mulRsv_r;
	assign nStageRatio = nRatio_r;
	assign mStageRatio = mRatio_r;
	assign pdmRatio = pdmRatio_r;
	assign pdmReserved = pdmRsv_r;
	assign modulatorRatio = modRatio_r;
	assign modulatorReserved = modRsv_r;
	assign primaryBclkRatio = priRatio_r;
	assign secondaryBclkRatio = secRatio_r;
	assign analogNmRatio = nmRatio_r;

	// Auto mode keeps the dividers running on auto ratios
	wire nEn = divEn_r[`ACD_BIT_N_EN] | autoDetectEn; // R12 R13
	wire mEn = divEn_r[`ACD_BIT_M_EN] | autoDetectEn; // R12 R13
	wire pdmEn = divEn_r[`ACD_BIT_PDM_EN] | autoDetectEn; // R12 R13

	acd_divider #(.W(10)) n_stage_divider (
		.clk(clk),
		.rst(rst),
		.enable(nEn), // R15
		.ratio(nStageRatio),
		.tick(nStageTick)
	);

	acd_divider #(.W(10)) m_stage_divider (
		.clk(clk),
		.rst(rst),
		.enable(mEn), // R15
		.ratio(mStageRatio),
		.tick(mStageTick)
	);

	acd_divider #(.W(10)) pdmDiv (
		.clk(clk),
		.rst(rst),
		.enable(pdmEn), // R15
		.ratio(pdmRatio),
		.tick(pdmTick)
	);
endmodule // acd_clock_divider_config

// >>> hdl/acd_consts.vh
// Register offsets, field positions and reset values of the clock-divider
// configuration block. Assumes an 8-bit register port addressed by byte.
`ifndef ACD_CONSTS_VH
`define ACD_CONSTS_VH

`define ACD_ADDR_W 8
`define ACD_OFF_PLL_MUL_HI 8'h36
`define ACD_OFF_PLL_MUL_LO 8'h38
`define ACD_OFF_N_PDM_SEL 8'h39
`define ACD_OFF_M_MOD_SEL 8'h3a
`define ACD_OFF_BCLK_HI 8'h3b
`define ACD_OFF_PRI_BCLK_LO 8'h3c
`define ACD_OFF_SEC_BCLK_LO 8'h3d
`define ACD_OFF_ANA_NM_SEL 8'h3e
`define ACD_OFF_DIV_EN 8'h44

`define ACD_RST_PLL_MUL_HI 8'h00
`define ACD_RST_PLL_MUL_LO 8'h08
`define ACD_RST_N_PDM_SEL 8'h20
`define ACD_RST_M_MOD_SEL 8'h04
`define ACD_RST_BCLK_HI 8'h00
`define ACD_RST_PRI_BCLK_LO 8'h01
`define ACD_RST_SEC_BCLK_LO 8'h01
`define ACD_RST_ANA_NM_SEL 8'h01
`define ACD_RST_DIV_EN 8'h00

// Writable masks; reserved bits read as zero
`define ACD_MASK_PLL_MUL_HI 8'h80
`define ACD_MASK_N_PDM_SEL 8'hfc
`define ACD_MASK_BCLK_HI 8'h06
`define ACD_MASK_ANA_NM_SEL 8'h3f
`define ACD_MASK_DIV_EN 8'h07

`define ACD_BIT_PLL_MUL_HI 7
`define ACD_BIT_PRI_BCLK_HI 2
`define ACD_BIT_SEC_BCLK_HI 1
`define ACD_BIT_N_EN 2
`define ACD_BIT_M_EN 1
`define ACD_BIT_PDM_EN 0

`define ACD_N_HI 7
`define ACD_N_LO 5
`define ACD_PDM_HI 4
`define ACD_PDM_LO 2
`define ACD_M_HI 7
`define ACD_M_LO 2
`define ACD_MOD_HI 1
`define ACD_MOD_LO 0
`define ACD_NM_HI 5
`define ACD_NM_LO 0

`endif

// >>> hdl/acd_divider.v
// One gated integer clock divider producing a clock-enable pulse train.
// Assumes ratio is stable or changes only while disabled for glitch-free use.
module acd_divider #(
	parameter W = 10
) (
	input wire clk,
	input wire rst,
	input wire enable,
	input wire [W-1:0] ratio,
	output wire tick
);
	reg [W-1:0] count_r;
	reg tick_r;

	assign tick = tick_r;

	// Disabled: counter parked at start and output held low
	always @(posedge clk)
	begin
		if (rst || !enable) // R15
		begin
			count_r <= {W{1'b0}};
			tick_r <= 1'b0;
		end
		else if (count_r >= ratio - {{(W-1){1'b0}}, 1'b1})
		begin
			count_r <= {W{1'b0}};
			tick_r <= 1'b1;
		end
		else
		begin
			count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
			tick_r <= 1'b0;
		end
	end
endmodule // acd_divider

// >>> tb/acd_cfg_asserts.sv
// Concurrent checks on the divider-config ports.
// Assumes one clock and a synchronous active-high reset.
module acd_cfg_asserts (
	input wire clk,
	input wire rst,
	input wire autoDetectEn,
	input wire [8:0] pllMultiplier,
	input wire multiplierReserved,
	input wire [9:0] nStageRatio,
	input wire [9:0] mStageRatio,
	input wire [9:0] pdmRatio,
	input wire pdmReserved,
	input wire [9:0] modulatorRatio,
	input wire [9:0] primaryBclkRatio,
	input wire nStageTick
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_mul_zero: assert property (
		multiplierReserved && !autoDetectEn |-> pllMultiplier == 9'h000)
		else $error("multiplier flag without zero code");
	a_n_range: assert property (
		nStageRatio inside {[10'd1:10'd8]})
		else $error("n ratio out of range");
	a_pdm_set: assert property (
		pdmRatio inside {10'd1, 10'd2, 10'd4, 10'd8, 10'd16})
		else $error("pdm ratio not a power of two");
	a_pdm_flag: assert property (
		pdmReserved |-> pdmRatio == 10'd1)
		else $error("reserved pdm code not ratio one");
	a_m_range: assert property (
		mStageRatio inside {[10'd1:10'd64]})
		else $error("m ratio out of range");
	a_mod_set: assert property (
		modulatorRatio inside {10'd1, 10'd2, 10'd4})
		else $error("modulator ratio not allowed");
	a_bclk_range: assert property (
		primaryBclkRatio inside {[10'd1:10'd512]})
		else $error("bit-clock ratio out of range");
	a_tick_pulse: assert property (
		nStageTick && nStageRatio > 10'd1 |=> !nStageTick)
		else $error("n tick longer than one cycle");
endmodule // acd_cfg_asserts

bind acd_clock_divider_config acd_cfg_asserts acd_cfg_asserts_i (.clk, .rst,
	.autoDetectEn, .pllMultiplier, .multiplierReserved, .nStageRatio,
	.mStageRatio, .pdmRatio, .pdmReserved, .modulatorRatio,
	.primaryBclkRatio, .nStageTick);

// >>> tb/acd_clock_divider_config_tb.sv
// Self-checking bench for the divider-config block.
// Sets its own automatic-mode ratios on the instance.
module acd_clock_divider_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, regWrite = 0, regRead = 0, autoDetectEn = 0;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
	wire [7:0] regRdData;
	wire [8:0] pllMultiplier;
	wire multiplierReserved, pdmReserved, modulatorReserved;
	wire [9:0] nStageRatio, mStageRatio, pdmRatio, modulatorRatio;
	wire [9:0] primaryBclkRatio, secondaryBclkRatio, analogNmRatio;
	wire [2:0] ticks;
	int fails = 0, comparisons = 0;
	logic [7:0] offs [9] = '{8'h36, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c,
		8'h3d, 8'h3e, 8'h44};
	logic [7:0] rsts [9] = '{8'h00, 8'h08, 8'h20, 8'h04, 8'h00, 8'h01,
		8'h01, 8'h01, 8'h00};
	logic [7:0] msks [9] = '{8'h80, 8'hff, 8'hfc, 8'hff, 8'h06, 8'hff,
		8'hff, 8'h3f, 8'h07};
	always #2 clk = ~clk;
	// Auto ratios differ from what is programmed just before auto mode
	acd_clock_divider_config #(.AUTO_MUL(9'd100), .AUTO_N(10'd3),
		.AUTO_M(10'd5), .AUTO_PDM(10'd4), .AUTO_MOD(10'd2),
		.AUTO_BCLK(10'd9), .AUTO_NM(10'd6))
		acd_clock_divider_config_i (.clk, .rst,
		.regAddr, .regWrData, .regWrite, .regRead, .regRdData,
		.autoDetectEn, .pllMultiplier, .multiplierReserved, .nStageRatio,
		.mStageRatio, .pdmRatio, .pdmReserved, .modulatorRatio,
		.modulatorReserved, .primaryBclkRatio, .secondaryBclkRatio,
		.analogNmRatio, .nStageTick(ticks[2]), .mStageTick(ticks[1]),
		.pdmTick(ticks[0]));
	task ck(input logic [9:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		ck(regRdData, e);
	endtask
	task ratios(input logic [9:0] m, n, s, b, a);
		repeat (3) @(posedge clk);
		#1 ck({1'b0, pllMultiplier}, m);
		ck(nStageRatio, n);
		ck(mStageRatio, s);
		ck(primaryBclkRatio, b);
		ck(secondaryBclkRatio, b);
		ck(analogNmRatio, a);
	endtask
	task t_reset;
		foreach (offs[i]) rd(offs[i], rsts[i]);
		ratios(8, 1, 1, 1, 1);
	endtask
	task t_max;
		// Reserved bits only ever written with their reset value
		foreach (offs[i]) wr(offs[i], msks[i]);
		foreach (offs[i]) rd(offs[i], msks[i]);
		rd(8'h40, 8'h00);
		ratios(511, 7, 63, 511, 63);
		ck(pdmRatio, 1);
		ck(pdmReserved, 1);
		ck(modulatorReserved, 1);
	endtask
	task t_auto;
		@(posedge clk) autoDetectEn <= 1'b1;
		ratios(100, 3, 5, 9, 6);
		ck(pdmRatio, 4);
		ck(modulatorRatio, 2);
		ck(pdmReserved, 0);
		ck(modulatorReserved, 0);
		ck(multiplierReserved, 0);
		@(posedge clk) autoDetectEn <= 1'b0;
	endtask
	task t_zero;
		foreach (offs[i]) wr(offs[i], 8'h00);
		ratios(0, 8, 64, 512, 64);
		ck(multiplierReserved, 1);
		wr(8'h3b, 8'h04);
		repeat (3) @(posedge clk);
		#1 ck(primaryBclkRatio, 256);
		ck(secondaryBclkRatio, 512);
		wr(8'h3b, 8'h02);
		repeat (3) @(posedge clk);
		#1 ck(primaryBclkRatio, 512);
		ck(secondaryBclkRatio, 256);
		wr(8'h3b, 8'h00);
	endtask
	task t_codes;
		for (int i = 0; i < 5; i++)
		begin
			wr(8'h39, 8'(i << 2));
			ratios(0, 8, 64, 512, 64);
			ck(pdmRatio, 10'(1 << i));
			ck(pdmReserved, 0);
		end
		for (int i = 0; i < 3; i++)
		begin
			wr(8'h3a, 8'(i));
			ratios(0, 8, 64, 512, 64);
			ck(modulatorRatio, 10'(1 << i));
			ck(modulatorReserved, 0);
		end
	endtask
	// Window is a whole number of periods, so phase does not matter
	task t_tick(input int b, r);
		int n;
		wr(8'h44, 8'(1 << b));
		repeat (5) @(posedge clk);
		n = 0;
		repeat (6 * r) @(posedge clk) #1 n += ticks[b];
		ck(10'(n), 6);
		wr(8'h44, 8'h00);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (20) @(posedge clk) #1 n += ticks[b];
		ck(10'(n), 0);
	endtask
	task results;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		#20000 fails++;
		results;
	end
	initial
	begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_max;
		t_auto;
		t_zero;
		t_codes;
		wr(8'h39, 8'h68);
		wr(8'h3a, 8'h14);
		t_tick(2, 3);
		t_tick(1, 5);
		t_tick(0, 4);
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		t_reset;
		results;
	end
endmodule // acd_clock_divider_config_tb
